// ---- rtl/ea_decoder.sv ----
// addressing-mode, segment and processor-control decoder
`timescale 1ns/100ps
`default_nettype none

module ea_decoder
  import ea_decode_pkg::*;
#(
  parameter int DATA_W = 16 // address and register width
)(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // instruction byte stream from the fetch queue
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_needs_modrm,
  input wire logic i_word,
  input wire logic i_string_dst,
  // register values from the datapath
  input wire logic [DATA_W-1:0] i_base_b,
  input wire logic [DATA_W-1:0] i_frame_ptr,
  input wire logic [DATA_W-1:0] i_src_idx,
  input wire logic [DATA_W-1:0] i_dst_idx,
  input wire logic i_carry,
  // stream handshake
  output logic o_byte_ready,
  // address results
  output logic o_ea_valid,
  output logic [DATA_W-1:0] o_effective_address,
  output logic [1:0] o_segment,
  output logic [1:0] o_disp_count,
  output logic [2:0] o_xfer_extra,
  // register operand results
  output logic o_reg_valid,
  output logic o_rm_is_reg,
  output logic [2:0] o_reg_sel,
  output logic o_reg_high,
  output logic [2:0] o_rm_sel,
  output logic o_rm_high,
  // processor control
  output logic o_op_done,
  output logic o_lock,
  output logic o_carry,
  output logic o_dir_flag,
  output logic o_irq_enable
);

  ////////////////////////////////////////////////////////////////
  // elaboration check

  // byte assembly of the displacement assumes a 16-bit core
  if (DATA_W != 16) begin : g_bad_width
    $error("ea_decoder supports only a 16-bit data width");
  end

  ////////////////////////////////////////////////////////////////
  // types and functions

  // decode sequencer states
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_DISP_LO,
    ST_DISP_HI,
    ST_EA_CALC,
    ST_SHORT
  } state_t;

  // byte register index: low halves 0-3, then high halves
  function automatic logic [3:0] reg_decode(input logic [2:0] code, input logic word);
    logic [3:0] res;
    res = {1'b0, code};
    if (!word) begin
      res = {code[2], 1'b0, code[1:0]};
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////
  // state

  state_t state_q, state_d; // sequencer
  logic [1:0] cnt_q, cnt_d; // cycles left in a timed state
  logic [7:0] opc_q; // opcode held through a short op
  logic word_q; // width bit of current instruction
  logic [2:0] xfer_q; // word transfer penalty hint, kept in a flop so the output is registered
  logic sdst_q; // operand is string destination
  logic [1:0] mode_q; // mode field latched
  logic [2:0] rm_q; // register/memory field latched
  logic [1:0] dcnt_q; // displacement byte count latched
  logic [DATA_W-1:0] disp_q, disp_d; // assembled displacement
  logic ovr_q; // segment override pending
  logic [1:0] ovr_seg_q; // overriding segment
  logic lock_pend_q; // lock prefix seen, waiting for target
  logic ready_q; // byte ready flop
  logic ea_valid_q; // address ready pulse
  logic [DATA_W-1:0] ea_q; // effective address result
  logic [1:0] seg_q; // segment result
  logic reg_valid_q; // register result pulse
  logic [2:0] reg_sel_q; // reg field selector
  logic reg_high_q; // reg field byte high half
  logic [2:0] rm_sel_q; // rm field selector in register mode
  logic rm_high_q; // rm field byte high half
  logic rm_is_reg_q; // mode 11 seen
  logic done_q; // instruction finished pulse
  logic lock_q; // bus lock output
  logic carry_q; // carry flag
  logic dir_q; // direction flag
  logic irq_q; // interrupt enable flag

  ////////////////////////////////////////////////////////////////
  // decoding of the incoming byte

  wire take = i_byte_valid && ready_q; // byte accepted this cycle
  wire is_seg_pfx = (i_byte[7:5] == SEG_PFX_TOP) && (i_byte[2:0] == SEG_PFX_BOT);
  wire is_lock = (i_byte == OPC_LOCK);
  wire is_flag_op = (i_byte == OPC_CARRY_INV) || (i_byte == OPC_DIR_SET) ||
                    (i_byte == OPC_DIR_CLR) || (i_byte == OPC_IRQ_CLR) ||
                    (i_byte == OPC_IRQ_SET);
  wire [1:0] byte_mode = i_byte[MODE_HI:MODE_LO];
  wire [2:0] byte_rm = i_byte[RM_HI:RM_LO];
  wire [2:0] byte_reg = i_byte[REG_HI:REG_LO];

  // field decode of the incoming mode byte
  logic f_is_reg, f_direct, f_use_src, f_use_dst;
  logic [1:0] f_disp_count;
  base_src_t f_base;

  modrm_fields u_fields (
    .i_mode(byte_mode),
    .i_rm(byte_rm),
    .o_is_reg(f_is_reg),
    .o_direct(f_direct),
    .o_disp_count(f_disp_count),
    .o_base(f_base),
    .o_use_src(f_use_src),
    .o_use_dst(f_use_dst)
  );

  // same field decode on the latched byte for the sum
  logic l_is_reg, l_direct, l_use_src, l_use_dst;
  logic [1:0] l_disp_count;
  base_src_t l_base;

  modrm_fields u_latched (
    .i_mode(mode_q),
    .i_rm(rm_q),
    .o_is_reg(l_is_reg),
    .o_direct(l_direct),
    .o_disp_count(l_disp_count),
    .o_base(l_base),
    .o_use_src(l_use_src),
    .o_use_dst(l_use_dst)
  );

  ////////////////////////////////////////////////////////////////
  // address sum and segment choice

  wire [DATA_W-1:0] base_val = (l_base == SRC_BASE_B) ? i_base_b :
                               (l_base == SRC_FRAME) ? i_frame_ptr :
                               '0;
  wire [DATA_W-1:0] idx_val = l_use_src ? i_src_idx :
                              l_use_dst ? i_dst_idx :
                              '0;
  // direct form carries the address in the displacement slot
  wire [DATA_W-1:0] ea_sum = DATA_W'(base_val + idx_val + disp_q);

  // precedence: string destination, override, frame pointer, data
  wire [1:0] seg_sel = sdst_q ? SEG_EXTRA :
                       ovr_q ? ovr_seg_q :
                       (l_base == SRC_FRAME) ? SEG_STACK :
                       SEG_DATA;

  // sign extension of a one-byte displacement
  wire [DATA_W-1:0] disp8_ext = {{(DATA_W-8){i_byte[7]}}, i_byte};

  // register field selection, both fields share the decode
  wire [3:0] reg_dec = reg_decode(byte_reg, word_q);
  wire [3:0] rm_dec = reg_decode(byte_rm, word_q);

  // word operand memory transfers take extra cycles
  wire [2:0] xfer_d = i_word ? WORD_XFER_EXTRA : 3'h0;

  ////////////////////////////////////////////////////////////////
  // sequencer next state

  // one mode byte, then displacement bytes, then the timed sum
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    disp_d = disp_q;
    case (state_q)
      ST_OPCODE: begin
        if (take && !is_seg_pfx) begin
          if (is_lock || is_flag_op) begin
            state_d = ST_SHORT;
            cnt_d = 2'(SHORT_OP_CYCLES - 2);
          end else if (i_needs_modrm) begin
            state_d = ST_MODRM;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          disp_d = '0;
          if (f_is_reg) begin
            state_d = ST_OPCODE;
          end else if (f_disp_count == 2'h0) begin
            state_d = ST_EA_CALC;
            cnt_d = 2'(EA_CALC_CYCLES - 1);
          end else begin
            state_d = ST_DISP_LO;
          end
        end
      end
      ST_DISP_LO: begin
        if (take) begin
          if (dcnt_q == 2'h1) begin
            disp_d = disp8_ext;
            state_d = ST_EA_CALC;
            cnt_d = 2'(EA_CALC_CYCLES - 1);
          end else begin
            disp_d = {{(DATA_W-8){1'b0}}, i_byte};
            state_d = ST_DISP_HI;
          end
        end
      end
      ST_DISP_HI: begin
        if (take) begin
          disp_d = {i_byte, disp_q[7:0]};
          state_d = ST_EA_CALC;
          cnt_d = 2'(EA_CALC_CYCLES - 1);
        end
      end
      ST_EA_CALC: begin
        if (cnt_q == 2'h0) begin
          state_d = ST_OPCODE;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      ST_SHORT: begin
        if (cnt_q == 2'h0) begin
          state_d = ST_OPCODE;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      default: begin
        state_d = ST_OPCODE;
      end
    endcase
  end

  // byte ready only in states that consume the stream
  wire ready_d = (state_d == ST_OPCODE) || (state_d == ST_MODRM) ||
                 (state_d == ST_DISP_LO) || (state_d == ST_DISP_HI);
  wire short_end = (state_q == ST_SHORT) && (cnt_q == 2'h0);
  wire ea_end = (state_q == ST_EA_CALC) && (cnt_q == 2'h0);
  wire reg_end = (state_q == ST_MODRM) && take && f_is_reg;
  wire plain_end = (state_q == ST_OPCODE) && take && !is_seg_pfx &&
                   !is_lock && !is_flag_op && !i_needs_modrm;
  // end of any instruction, the lock prefix not counting as one
  wire instr_end = ea_end || reg_end || plain_end ||
                   (short_end && (opc_q != OPC_LOCK));

  ////////////////////////////////////////////////////////////////
  // sequencer and latches

  // state, counters and per-instruction context
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_OPCODE;
      cnt_q <= 2'h0;
      disp_q <= '0;
      ready_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      disp_q <= disp_d;
      ready_q <= ready_d;
    end
  end

  // opcode context, latched with the opcode byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      opc_q <= 8'h00;
      word_q <= 1'b0;
      xfer_q <= 3'h0;
      sdst_q <= 1'b0;
    end else if (i_ce && take && state_q == ST_OPCODE && !is_seg_pfx) begin
      opc_q <= i_byte;
      word_q <= i_word;
      xfer_q <= xfer_d;
      sdst_q <= i_string_dst;
    end
  end

  // mode byte fields, latched on the mode byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= MODE_NO_DISP;
      rm_q <= 3'h0;
      dcnt_q <= 2'h0;
    end else if (i_ce && take && state_q == ST_MODRM) begin
      mode_q <= byte_mode;
      rm_q <= byte_rm;
      dcnt_q <= f_disp_count;
    end
  end

  ////////////////////////////////////////////////////////////////
  // prefixes

  // override and lock last until the next instruction ends
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ovr_q <= 1'b0;
      ovr_seg_q <= SEG_DATA;
      lock_pend_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (i_ce) begin
      if (state_q == ST_OPCODE && take && is_seg_pfx) begin
        ovr_q <= 1'b1;
        ovr_seg_q <= i_byte[SEG_PFX_HI:SEG_PFX_LO];
      end else if (instr_end) begin
        ovr_q <= 1'b0;
      end
      if (short_end && opc_q == OPC_LOCK) begin
        lock_pend_q <= 1'b1;
        lock_q <= 1'b1;
      end else if (instr_end) begin
        // lock drops only once the locked instruction is over
        lock_pend_q <= 1'b0;
        lock_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // results

  // address, segment and register results
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ea_valid_q <= 1'b0;
      ea_q <= '0;
      seg_q <= SEG_DATA;
      reg_valid_q <= 1'b0;
      reg_sel_q <= 3'h0;
      reg_high_q <= 1'b0;
      rm_sel_q <= 3'h0;
      rm_high_q <= 1'b0;
      rm_is_reg_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      ea_valid_q <= ea_end;
      done_q <= instr_end;
      reg_valid_q <= (state_q == ST_MODRM) && take;
      if (ea_end) begin
        ea_q <= ea_sum;
        seg_q <= seg_sel;
      end
      if (state_q == ST_MODRM && take) begin
        reg_sel_q <= reg_dec[2:0];
        reg_high_q <= reg_dec[3];
        rm_sel_q <= rm_dec[2:0];
        rm_high_q <= rm_dec[3];
        rm_is_reg_q <= f_is_reg;
      end
    end
  end

  // flags changed by the processor-control opcodes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      carry_q <= CARRY_RST;
      dir_q <= DIR_RST;
      irq_q <= IRQ_RST;
    end else if (i_ce && short_end) begin
      case (opc_q)
        OPC_CARRY_INV: carry_q <= ~i_carry;
        OPC_DIR_SET: dir_q <= 1'b1;
        OPC_DIR_CLR: dir_q <= 1'b0;
        OPC_IRQ_CLR: irq_q <= 1'b0;
        OPC_IRQ_SET: irq_q <= 1'b1;
        default: carry_q <= carry_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign o_byte_ready = ready_q;
  assign o_ea_valid = ea_valid_q;
  assign o_effective_address = ea_q;
  assign o_segment = seg_q;
  assign o_disp_count = dcnt_q;
  assign o_xfer_extra = xfer_q;
  assign o_reg_valid = reg_valid_q;
  assign o_rm_is_reg = rm_is_reg_q;
  assign o_reg_sel = reg_sel_q;
  assign o_reg_high = reg_high_q;
  assign o_rm_sel = rm_sel_q;
  assign o_rm_high = rm_high_q;
  assign o_op_done = done_q;
  assign o_lock = lock_q;
  assign o_carry = carry_q;
  assign o_dir_flag = dir_q;
  assign o_irq_enable = irq_q;

endmodule

`default_nettype wire

// ---- shared/ea_decode_pkg.sv ----
// constants for the addressing-mode and processor-control decoder
package ea_decode_pkg;

  // mode field encodings
  localparam logic [1:0] MODE_NO_DISP = 2'h0;
  localparam logic [1:0] MODE_DISP8 = 2'h1;
  localparam logic [1:0] MODE_DISP16 = 2'h2;
  localparam logic [1:0] MODE_REG = 2'h3;

  // register/memory code that means direct address under mode 00
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // field positions inside the addressing-mode byte
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 3;
  localparam int RM_HI = 2;
  localparam int RM_LO = 0;

  // segment override prefix: 001 ss 110
  localparam logic [2:0] SEG_PFX_TOP = 3'h1;
  localparam logic [2:0] SEG_PFX_BOT = 3'h6;
  localparam int SEG_PFX_HI = 4;
  localparam int SEG_PFX_LO = 3;

  // segment selector codes
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // processor-control opcodes
  localparam logic [7:0] OPC_LOCK = 8'hF0;
  localparam logic [7:0] OPC_CARRY_INV = 8'hF5;
  localparam logic [7:0] OPC_IRQ_CLR = 8'hFA;
  localparam logic [7:0] OPC_IRQ_SET = 8'hFB;
  localparam logic [7:0] OPC_DIR_CLR = 8'hFC;
  localparam logic [7:0] OPC_DIR_SET = 8'hFD;

  // timing, in core clock cycles
  localparam int EA_CALC_CYCLES = 4;
  localparam int SHORT_OP_CYCLES = 2;
  localparam logic [2:0] WORD_XFER_EXTRA = 3'h4;

  // reset values of the flags held here
  localparam logic CARRY_RST = 1'b0;
  localparam logic DIR_RST = 1'b0;
  localparam logic IRQ_RST = 1'b0;

  // base registers named by the register/memory code
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_BASE_B,
    SRC_FRAME
  } base_src_t;

endpackage

// ---- rtl/modrm_fields.sv ----
// combinational split of the mode and register/memory fields
`timescale 1ns/100ps
`default_nettype none

module modrm_fields
  import ea_decode_pkg::*;
(
  // fields from the addressing-mode byte
  input wire logic [1:0] i_mode,
  input wire logic [2:0] i_rm,
  // decoded selection
  output logic o_is_reg,
  output logic o_direct,
  output logic [1:0] o_disp_count,
  output base_src_t o_base,
  output logic o_use_src,
  output logic o_use_dst
);

  // register operand, no memory address at all
  assign o_is_reg = (i_mode == MODE_REG);
  // direct address replaces the frame pointer case
  assign o_direct = (i_mode == MODE_NO_DISP) && (i_rm == RM_DIRECT);

  // bytes the fetch unit must supply after the mode byte
  assign o_disp_count = o_is_reg ? 2'h0 :
                        o_direct ? 2'h2 :
                        (i_mode == MODE_DISP8) ? 2'h1 :
                        (i_mode == MODE_DISP16) ? 2'h2 :
                        2'h0;

  // base register: pairs first, then single registers
  assign o_base = o_direct ? SRC_NONE :
                  (i_rm == 3'h0 || i_rm == 3'h1 || i_rm == 3'h7) ? SRC_BASE_B :
                  (i_rm == 3'h2 || i_rm == 3'h3 || i_rm == 3'h6) ? SRC_FRAME :
                  SRC_NONE;

  // index registers
  assign o_use_src = (i_rm == 3'h0) || (i_rm == 3'h2) || (i_rm == 3'h4);
  assign o_use_dst = (i_rm == 3'h1) || (i_rm == 3'h3) || (i_rm == 3'h5);

endmodule

`default_nettype wire

// ---- sim/fetch_queue_model.sv ----
// fetch queue model that offers instruction bytes to the decoder
`timescale 1ns/100ps
`default_nettype none

module fetch_queue_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // acceptance from the decoder and pacing
  input wire logic i_ready,
  input wire logic i_slow,
  // offered byte and its side bits
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_needs_modrm,
  output logic o_word,
  output logic o_string_dst
);
  logic [10:0] q [$]; // pending entries: string, word, mode flag, byte
  logic [10:0] head_q; // entry on offer
  logic took; // byte accepted at this edge
  assign took = o_valid && i_ready;
  assign {o_string_dst, o_word, o_needs_modrm, o_byte} = head_q;
  ////////////////////////////////////////////////////////////
  // the bench appends whole instructions, bytes in stream order
  function automatic void push(input logic [10:0] e);
    q.push_back(e);
  endfunction
  // hold an entry until taken; idle lines flip every cycle so stale data never matches
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      head_q <= 11'h000;
    end else begin
      // strict stream order, displacement right after the mode byte
      if (took) begin
        void'(q.pop_front());
      end
      // slow pacing leaves a gap after every accepted byte
      if (q.size() > 0 && !(i_slow && took)) begin
        o_valid <= 1'b1;
        head_q <= q[0];
      end else begin
        o_valid <= 1'b0;
        head_q <= ~head_q;
      end
    end
  end
endmodule

`default_nettype wire

// ---- sim/ea_decoder_props.sv ----
// assertion checker for the addressing-mode decoder ports
`timescale 1ns/100ps
`default_nettype none

module ea_decoder_props (
  // clock, reset and stream
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_byte_valid,
  input wire logic o_byte_ready,
  // results
  input wire logic o_ea_valid,
  input wire logic o_op_done,
  input wire logic [1:0] o_disp_count,
  input wire logic [2:0] o_xfer_extra,
  input wire logic o_reg_valid,
  input wire logic o_rm_is_reg,
  input wire logic [2:0] o_reg_sel,
  input wire logic o_reg_high,
  // flags and lock
  input wire logic o_lock,
  input wire logic o_carry,
  input wire logic o_dir_flag,
  input wire logic o_irq_enable
);
  logic take; // byte accepted at this edge
  assign take = i_ce && i_byte_valid && o_byte_ready;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // address: fixed latency after the last byte, stream refused meanwhile
  a_calc_delay: assert property (o_ea_valid |-> $past(take, 5) && o_op_done)
    else $error("address result not five edges after last byte");
  a_calc_busy: assert property (o_ea_valid |-> !$past(o_byte_ready, 1) && !$past(o_byte_ready, 4))
    else $error("stream accepted during address calculation");
  a_disp_count: assert property (o_disp_count != 2'h3)
    else $error("displacement count out of range");
  a_xfer_extra: assert property (o_xfer_extra == 3'h0 || o_xfer_extra == 3'h4)
    else $error("transfer penalty neither zero nor four");
  // short flag operations end two edges after the opcode
  a_carry_time: assert property ($changed(o_carry) |-> o_op_done && !$past(o_byte_ready))
    else $error("carry changed outside a finished short op");
  a_dir_time: assert property ($changed(o_dir_flag) |-> o_op_done && !$past(o_byte_ready))
    else $error("direction flag changed outside a finished short op");
  a_irq_time: assert property ($changed(o_irq_enable) |-> $past(take, 2) && o_op_done)
    else $error("enable flag changed at wrong time");
  // lock covers exactly the following instruction
  a_lock_rise: assert property ($rose(o_lock) |-> $past(take, 2) && !o_op_done)
    else $error("lock rose at wrong time");
  a_lock_drop: assert property ($fell(o_lock) |-> o_op_done)
    else $error("lock dropped before the locked instruction ended");
  // register form gives no address and ends at once
  a_reg_only: assert property (o_reg_valid && o_rm_is_reg |-> o_op_done && !o_ea_valid && $past(take))
    else $error("register form produced an address or late end");
  a_byte_half: assert property (o_reg_valid |-> !(o_reg_high && o_reg_sel[2]))
    else $error("high byte half with selector above three");
  c_mem: cover property (o_ea_valid && o_disp_count == 2'h2);
  c_reg: cover property (o_reg_valid && o_rm_is_reg);
  c_lock: cover property ($rose(o_lock));
endmodule

bind ea_decoder ea_decoder_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_byte_valid(i_byte_valid),
  .o_byte_ready(o_byte_ready), .o_ea_valid(o_ea_valid), .o_op_done(o_op_done), .o_disp_count(o_disp_count),
  .o_xfer_extra(o_xfer_extra), .o_reg_valid(o_reg_valid), .o_rm_is_reg(o_rm_is_reg), .o_reg_sel(o_reg_sel),
  .o_reg_high(o_reg_high), .o_lock(o_lock), .o_carry(o_carry), .o_dir_flag(o_dir_flag),
  .o_irq_enable(o_irq_enable));

`default_nettype wire

// ---- sim/tb_ea_decoder.sv ----
// self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
`default_nettype none

module tb_ea_decoder;
  import ea_decode_pkg::*;
  // row: mode byte, displacement bytes, expected address, segment, count
  typedef struct packed {
    logic [7:0] m;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [15:0] ea;
    logic [1:0] seg;
    logic [1:0] cnt;
  } row_t;
  // registers held at base_b 1000, frame_ptr 2000, src_idx 0030, dst_idx 0400
  row_t rows [9] = '{'{8'h00, 8'h00, 8'h00, 16'h1030, 2'h3, 2'h0}, '{8'h41, 8'h80, 8'h00, 16'h1380, 2'h3, 2'h1},
    '{8'h82, 8'h34, 8'h12, 16'h3264, 2'h2, 2'h2}, '{8'h03, 8'h00, 8'h00, 16'h2400, 2'h2, 2'h0},
    '{8'h44, 8'h7F, 8'h00, 16'h00AF, 2'h3, 2'h1}, '{8'h85, 8'hFF, 8'hFF, 16'h03FF, 2'h3, 2'h2},
    '{8'h46, 8'hFE, 8'h00, 16'h1FFE, 2'h2, 2'h1}, '{8'h07, 8'h00, 8'h00, 16'h1000, 2'h3, 2'h0},
    '{8'h06, 8'h78, 8'h56, 16'h5678, 2'h3, 2'h2}};
  // flag opcode beside the carry, direction and enable flags it leaves
  logic [10:0] flag_ops [5] = '{{3'h4, 8'hF5}, {3'h6, 8'hFD}, {3'h7, 8'hFB}, {3'h5, 8'hFC}, {3'h4, 8'hFA}};
  logic i_clk, i_rst, i_ce, i_carry, slow, w, sd;
  logic fq_valid, fq_modrm, fq_word, fq_sd, o_byte_ready, o_ea_valid, o_reg_valid, o_rm_is_reg;
  logic o_reg_high, o_rm_high, o_op_done, o_lock, o_carry, o_dir_flag, o_irq_enable;
  logic [7:0] fq_byte;
  logic [15:0] o_effective_address;
  logic [1:0] o_segment, o_disp_count;
  logic [2:0] o_xfer_extra, o_reg_sel, o_rm_sel;
  row_t r;
  int errors, compares, cyc;
  ////////////////////////////////////////////////////////////
  fetch_queue_model fq (.i_clk(i_clk), .i_rst(i_rst), .i_ready(o_byte_ready), .i_slow(slow), .o_valid(fq_valid),
    .o_byte(fq_byte), .o_needs_modrm(fq_modrm), .o_word(fq_word), .o_string_dst(fq_sd));
  ea_decoder uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_byte_valid(fq_valid), .i_byte(fq_byte),
    .i_needs_modrm(fq_modrm), .i_word(fq_word), .i_string_dst(fq_sd), .i_base_b(16'h1000),
    .i_frame_ptr(16'h2000), .i_src_idx(16'h0030), .i_dst_idx(16'h0400), .i_carry(i_carry),
    .o_byte_ready(o_byte_ready), .o_ea_valid(o_ea_valid), .o_effective_address(o_effective_address),
    .o_segment(o_segment), .o_disp_count(o_disp_count), .o_xfer_extra(o_xfer_extra), .o_reg_valid(o_reg_valid),
    .o_rm_is_reg(o_rm_is_reg), .o_reg_sel(o_reg_sel), .o_reg_high(o_reg_high), .o_rm_sel(o_rm_sel),
    .o_rm_high(o_rm_high), .o_op_done(o_op_done), .o_lock(o_lock), .o_carry(o_carry),
    .o_dir_flag(o_dir_flag), .o_irq_enable(o_irq_enable));
  ////////////////////////////////////////////////////////////
  // compare tasks: addresses and small fields
  task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_f(input string n, input logic [2:0] e, input logic [2:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait for the end of an instruction, sampled mid-cycle
  task automatic wait_done;
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_op_done !== 1'b1 && n < 80) begin
      n++;
      @(negedge i_clk);
    end
    chk_f("done", 3'h1, {2'h0, o_op_done});
  endtask
  // opcode, mode byte, then as many displacement bytes as the mode asks
  task automatic push_row(input row_t x);
    fq.push({sd, w, 1'b1, 8'h8B});
    fq.push({3'h0, x.m});
    if (x.cnt > 0) fq.push({3'h0, x.d0});
    if (x.cnt > 1) fq.push({3'h0, x.d1});
  endtask
  task automatic check_row(input row_t x);
    wait_done;
    chk_f("ea valid", 3'h1, {2'h0, o_ea_valid});
    chk_w("address", x.ea, o_effective_address);
    chk_f("segment", {1'b0, x.seg}, {1'b0, o_segment});
    chk_f("disp count", {1'b0, x.cnt}, {1'b0, o_disp_count});
  endtask
  task automatic run_row(input row_t x);
    push_row(x);
    check_row(x);
  endtask
  ////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test;
    end
  end
  // main sequence
  initial begin
    {i_rst, i_ce, i_carry, slow, w, sd} = 6'b110000;
    {errors, compares, cyc} = '0;
    repeat (8) @(posedge i_clk);
    chk_f("reset state", 3'h6, {o_segment, o_byte_ready});
    i_rst <= 1'b0;
    foreach (rows[k]) run_row(rows[k]);
    // back to back: the second waits out the first calculation
    push_row(rows[3]);
    push_row(rows[8]);
    check_row(rows[3]);
    check_row(rows[8]);
    // every override on a frame-based operand, then one without
    for (int s = 0; s < 4; s++) begin
      r = rows[2];
      r.seg = s[1:0];
      fq.push({3'h0, 3'h1, s[1:0], 3'h6});
      run_row(r);
    end
    run_row(rows[6]);
    // string destination ignores a code-segment override
    sd = 1'b1;
    r = rows[5];
    r.seg = 2'h0;
    fq.push({3'h0, 8'h2E});
    run_row(r);
    sd = 1'b0;
    // word width with a stalling queue, then byte width
    {w, slow} = 2'b11;
    run_row(rows[2]);
    chk_f("xfer extra", 3'h4, o_xfer_extra);
    {w, slow} = 2'b00;
    run_row(rows[0]);
    chk_f("xfer extra", 3'h0, o_xfer_extra);
    // register form, reg field 101 and rm field 110, both widths
    for (int k = 0; k < 2; k++) begin
      w = k[0];
      r = '{8'hEE, 8'h00, 8'h00, 16'h0000, 2'h0, 2'h0};
      push_row(r);
      wait_done;
      chk_f("reg form", 3'h6, {o_reg_valid, o_rm_is_reg, o_ea_valid});
      chk_f("reg field", k ? 3'h5 : 3'h1, o_reg_sel);
      chk_f("rm field", k ? 3'h6 : 3'h2, o_rm_sel);
      chk_f("high halves", k ? 3'h0 : 3'h3, {1'b0, o_reg_high, o_rm_high});
    end
    // flag opcodes, the carry inverted from a clear carry
    @(posedge i_clk);
    i_carry <= 1'b0;
    foreach (flag_ops[k]) begin
      fq.push({3'h0, flag_ops[k][7:0]});
      wait_done;
      chk_f("flags", flag_ops[k][10:8], {o_carry, o_dir_flag, o_irq_enable});
    end
    // lock prefix lasts through the next instruction only
    fq.push({3'h0, 8'hF0});
    fq.push({3'h0, 8'h90});
    // lock stands while the locked opcode is offered, drops as it ends
    repeat (3) @(negedge i_clk);
    chk_f("lock held", 3'h1, {2'h0, o_lock});
    wait_done;
    chk_f("lock gone", 3'h0, {2'h0, o_lock});
    // second reset in mid-run clears the flags
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_f("flags after reset", 3'h0, {o_carry, o_dir_flag, o_irq_enable});
    run_row(rows[1]);
    stop_test;
  end
endmodule

`default_nettype wire
